// ===== core/wdt_core.sv
// Watchdog timer with interval interrupt and AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "wdt_params.svh"
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module wdt_core #(
    parameter int CNT_W = 16
) (
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic LS_CLOCK_I,
    input wire logic [4:0] OPTION_I,
    input wire logic STANDBY_I,
    input wire logic [wdt_pkg::ADDR_W-1:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [wdt_pkg::ADDR_W-1:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    output logic IRQ_O,
    output logic INTERVAL_IRQ_O,
    output logic RESET_REQ_O
);

    // Elaboration check: the longest overflow point must fit the counter
    if (CNT_W < 16) begin : g_cnt_w_check
        $error("CNT_W must hold the longest overflow point");
    end

    // ------------------------------------------------------------------
    // Synchronisers and option latch
    // ------------------------------------------------------------------
    logic ls_s1, ls_s2, ls_s3;
    logic stby_s1, stby_s2;
    logic [4:0] opt_s1, opt_s2;
    wdt_pkg::option_t opt;
    logic tick;

    // Pins from other domains pass two flops before any logic reads them
    always_ff @(posedge CLOCK_I) begin
        ls_s1 <= LS_CLOCK_I;
        ls_s2 <= ls_s1;
        ls_s3 <= ls_s2;
        stby_s1 <= STANDBY_I;
        stby_s2 <= stby_s1;
        opt_s1 <= OPTION_I;
        opt_s2 <= opt_s1;
    end

    // Option byte is sampled while reset is held, then frozen
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            opt <= wdt_pkg::option_t'(opt_s2);
        end
    end

    // One tick per low-speed rising edge; sync jitter is the slack
    assign tick = ls_s2 & ~ls_s3;

    // ------------------------------------------------------------------
    // Overflow point and interval threshold
    // ------------------------------------------------------------------
    logic [15:0] ovf_point;
    logic [16:0] thresh;

    // Period selected by the option code
    always_comb begin
        case (opt.overflow_select)
            3'h0: ovf_point = `WDT_OVF_0;
            3'h1: ovf_point = `WDT_OVF_1;
            3'h2: ovf_point = `WDT_OVF_2;
            3'h3: ovf_point = `WDT_OVF_3;
            3'h4: ovf_point = `WDT_OVF_4;
            3'h5: ovf_point = `WDT_OVF_5;
            3'h6: ovf_point = `WDT_OVF_6;
            default: ovf_point = `WDT_OVF_7;
        endcase
    end

    // 3/4 of (N + 1) ticks equals 3/4 of the period plus 3/4 tick
    always_comb begin
        thresh = 17'(({1'b0, ovf_point} + 17'h00001) >> 2) * 17'h00003;
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------------
    logic aw_have, w_have;
    logic [wdt_pkg::ADDR_W-1:0] aw_addr;
    logic [7:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic [19:0] wr_idx;
    logic kick, violation;
    logic [7:0] st_clear, mask;

    assign wr_fire = aw_have & w_have & ~BVALID_O;
    assign wr_idx = aw_addr[wdt_pkg::ADDR_W-1:2];

    // Address and data are taken in either order and held until used
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            AWREADY_O <= 1'b1;
            WREADY_O <= 1'b1;
            aw_addr <= '0;
            w_data <= 8'h00;
            w_strb <= 4'h0;
        end else begin
            if (AWVALID_I && AWREADY_O) begin
                aw_have <= 1'b1;
                aw_addr <= AWADDR_I;
                AWREADY_O <= 1'b0;
            end else if (wr_fire) begin
                aw_have <= 1'b0;
            end
            if (WVALID_I && WREADY_O) begin
                w_have <= 1'b1;
                w_data <= WDATA_I[7:0];
                w_strb <= WSTRB_I;
                WREADY_O <= 1'b0;
            end else if (wr_fire) begin
                w_have <= 1'b0;
            end
            if (BVALID_O && BREADY_I) begin
                AWREADY_O <= 1'b1;
                WREADY_O <= 1'b1;
            end
        end
    end

    // Decode of a completed write
    always_comb begin
        kick = 1'b0;
        violation = 1'b0;
        st_clear = 8'h00;
        if (!wr_fire) begin
            kick = 1'b0;
        end else if (wr_idx == `WDT_SERVICE_IDX) begin
            // Anything but a whole byte of the key is a runaway program
            if (w_strb != `WDT_BYTE_STRB) begin
                violation = 1'b1;
            end else if (w_data != `WDT_SERVICE_KEY) begin
                violation = 1'b1;
            end else begin
                kick = 1'b1;
            end
        end else if (wr_idx == `WDT_STATUS_IDX) begin
            st_clear = w_strb[0] ? (w_data & `WDT_ST_USED) : 8'h00;
        end
    end

    // Write answer, error for unmapped addresses
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            BVALID_O <= 1'b0;
            BRESP_O <= `WDT_RESP_OKAY;
        end else if (wr_fire) begin
            BVALID_O <= 1'b1;
            if (wr_idx == `WDT_SERVICE_IDX || wr_idx == `WDT_STATUS_IDX ||
                wr_idx == `WDT_MASK_IDX) begin
                BRESP_O <= `WDT_RESP_OKAY;
            end else begin
                BRESP_O <= `WDT_RESP_SLVERR;
            end
        end else if (BREADY_I) begin
            BVALID_O <= 1'b0;
        end
    end

    // Mask register, same layout as status
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            mask <= `WDT_MASK_RESET;
        end else if (wr_fire && wr_idx == `WDT_MASK_IDX && w_strb[0]) begin
            mask <= w_data & `WDT_ST_USED;
        end
    end

    // ------------------------------------------------------------------
    // Counter and mode
    // ------------------------------------------------------------------
    wdt_pkg::mode_t mode;
    logic [CNT_W-1:0] count;
    logic overflow, interval_hit, wdt_event;

    // Standby stops the count only when standby running is not opted
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            mode <= wdt_pkg::ST_OFF;
        end else begin
            case (mode)
                wdt_pkg::ST_OFF: begin
                    if (opt.count_enable_option) begin
                        mode <= wdt_pkg::ST_RUN;
                    end
                end
                wdt_pkg::ST_RUN: begin
                    if (stby_s2 && !opt.standby_run_option) begin
                        mode <= wdt_pkg::ST_HOLD;
                    end
                end
                wdt_pkg::ST_HOLD: begin
                    if (!stby_s2) begin
                        mode <= wdt_pkg::ST_RUN;
                    end
                end
                default: mode <= wdt_pkg::ST_OFF;
            endcase
        end
    end

    assign overflow = (mode == wdt_pkg::ST_RUN) && tick &&
        (count == CNT_W'(ovf_point - 16'h0001));
    assign interval_hit = (mode == wdt_pkg::ST_RUN) && tick && !violation &&
        (CNT_W'(count + 1'b1) == CNT_W'(thresh));
    // A key in the final count beats the overflow in the same cycle
    assign wdt_event = (overflow && !kick) || violation;

    // Count held at zero outside RUN, so standby exit starts fresh
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            count <= '0;
        end else if (kick || wdt_event) begin
            count <= '0;
        end else if (mode != wdt_pkg::ST_RUN) begin
            count <= '0;
        end else if (tick) begin
            count <= count + 1'b1;
        end
    end

    // Reset request and interval pulse, one cycle each
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            RESET_REQ_O <= 1'b0;
            INTERVAL_IRQ_O <= 1'b0;
        end else begin
            RESET_REQ_O <= wdt_event;
            INTERVAL_IRQ_O <= interval_hit && !kick;
        end
    end

    // ------------------------------------------------------------------
    // Status, interrupt
    // ------------------------------------------------------------------
    logic [7:0] status, st_set;

    always_comb begin
        st_set = 8'h00;
        st_set[`WDT_ST_INTERVAL_BIT] = interval_hit && !kick;
        st_set[`WDT_ST_RESET_BIT] = wdt_event;
    end

    // Sticky bits; a set in the clearing cycle wins
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            status <= 8'h00;
        end else begin
            status <= (status & ~st_clear) | st_set;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            IRQ_O <= 1'b0;
        end else begin
            IRQ_O <= |(status & mask);
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------------
    logic [19:0] rd_idx;
    logic rd_service;

    assign rd_idx = ARADDR_I[wdt_pkg::ADDR_W-1:2];

    // Service register reads a fixed code, never the key
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ARREADY_O <= 1'b1;
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h0000_0000;
            RRESP_O <= `WDT_RESP_OKAY;
            rd_service <= 1'b0;
        end else if (ARVALID_I && ARREADY_O) begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b1;
            RRESP_O <= `WDT_RESP_OKAY;
            rd_service <= 1'b0;
            if (rd_idx == `WDT_SERVICE_IDX) begin
                rd_service <= 1'b1;
                RDATA_O <= {24'h000000, opt.count_enable_option ?
                    `WDT_READ_ENABLED : `WDT_READ_DISABLED};
            end else if (rd_idx == `WDT_STATUS_IDX) begin
                RDATA_O <= {24'h000000, status};
            end else if (rd_idx == `WDT_MASK_IDX) begin
                RDATA_O <= {24'h000000, mask};
            end else begin
                RDATA_O <= 32'h0000_0000;
                RRESP_O <= `WDT_RESP_SLVERR;
            end
        end else if (RVALID_O && RREADY_I) begin
            RVALID_O <= 1'b0;
            ARREADY_O <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);

    sequence wr_done_s;
        BVALID_O && BREADY_I;
    endsequence

    sequence rd_take_s;
        ARVALID_I && ARREADY_O;
    endsequence

    kick_clears_count_a: assert property (kick |=> count == '0)
        else $error("Service key did not clear the counter");
    bad_key_reset_a: assert property (
        wr_fire && wr_idx == `WDT_SERVICE_IDX &&
        w_strb == `WDT_BYTE_STRB && w_data != `WDT_SERVICE_KEY
        |=> RESET_REQ_O && status[`WDT_ST_RESET_BIT])
        else $error("Wrong key did not raise reset");
    bit_access_reset_a: assert property (
        wr_fire && wr_idx == `WDT_SERVICE_IDX &&
        w_strb != `WDT_BYTE_STRB |=> RESET_REQ_O)
        else $error("Partial access did not raise reset");
    overflow_reset_a: assert property (
        overflow && !kick |=> RESET_REQ_O && count == '0)
        else $error("Overflow did not raise reset");
    late_kick_safe_a: assert property (
        overflow && kick && !violation |=> !RESET_REQ_O)
        else $error("Late service still caused reset");
    flag_follows_a: assert property (
        RESET_REQ_O |-> status[`WDT_ST_RESET_BIT])
        else $error("Reset cause flag not set");
    interval_once_a: assert property (
        INTERVAL_IRQ_O |=> !INTERVAL_IRQ_O)
        else $error("Interval request longer than one cycle");
    interval_point_a: assert property (
        INTERVAL_IRQ_O |-> count == CNT_W'(thresh))
        else $error("Interval request at wrong count");
    stopped_quiet_a: assert property (
        !opt.count_enable_option |-> count == '0 && !INTERVAL_IRQ_O)
        else $error("Disabled watchdog is counting");
    standby_hold_a: assert property (
        mode == wdt_pkg::ST_HOLD |=> count == '0)
        else $error("Counter moved in standby");
    service_read_a: assert property (
        RVALID_O && rd_service |-> RDATA_O[7:0] ==
        (opt.count_enable_option ? `WDT_READ_ENABLED : `WDT_READ_DISABLED))
        else $error("Service register read wrong code");
    bus_reopen_a: assert property (wr_done_s |=> AWREADY_O && WREADY_O)
        else $error("Write channels not reopened");
    read_answer_a: assert property (rd_take_s |=> RVALID_O && !ARREADY_O)
        else $error("Read not answered next cycle");

endmodule

// ===== shared/wdt_params.svh
// Offsets, field positions, reset values and counts of the watchdog block
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define WDT_SERVICE_IDX 20'hfffab
`define WDT_STATUS_IDX 20'hfff00
`define WDT_MASK_IDX 20'hfff01

// ----------------------------------------------------------------------
// Service register values
// ----------------------------------------------------------------------
`define WDT_SERVICE_KEY 8'hac
`define WDT_READ_DISABLED 8'h1a
`define WDT_READ_ENABLED 8'h9a
`define WDT_BYTE_STRB 4'h1

// ----------------------------------------------------------------------
// Status and mask layout
// ----------------------------------------------------------------------
`define WDT_ST_INTERVAL_BIT 0
`define WDT_ST_RESET_BIT 4
`define WDT_ST_USED 8'h11
`define WDT_MASK_RESET 8'h00

// ----------------------------------------------------------------------
// Overflow points in low-speed clock periods, per select code
// ----------------------------------------------------------------------
`define WDT_OVF_0 16'h003f
`define WDT_OVF_1 16'h007f
`define WDT_OVF_2 16'h00ff
`define WDT_OVF_3 16'h01ff
`define WDT_OVF_4 16'h07ff
`define WDT_OVF_5 16'h1fff
`define WDT_OVF_6 16'h3fff
`define WDT_OVF_7 16'hffff

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// ===== shared/wdt_pkg.sv
// Types shared by the watchdog block
package wdt_pkg;

    localparam int ADDR_W = 22;

    // Option byte bits 4..0 as latched at reset
    typedef struct packed {
        logic count_enable_option;
        logic [2:0] overflow_select;
        logic standby_run_option;
    } option_t;

    // Counter modes, one-hot
    typedef enum logic [2:0] {
        ST_OFF = 3'h1,
        ST_RUN = 3'h2,
        ST_HOLD = 3'h4
    } mode_t;

endpackage

// ===== verif/watchdog_timer_with_interval_irq_test.sv
// Self-checking bench for the watchdog timer block
`timescale 1ns/10ps
`include "wdt_params.svh"
module watchdog_timer_with_interval_irq_test;
    localparam logic [21:0] SVC_A = {`WDT_SERVICE_IDX, 2'h0};
    localparam logic [21:0] STS_A = {`WDT_STATUS_IDX, 2'h0};
    localparam logic [21:0] MSK_A = {`WDT_MASK_IDX, 2'h0};
    localparam logic [21:0] BAD_A = 22'h000100;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ls_clock = 1'b0;
    logic [4:0] option = 5'h10;
    logic standby = 1'b0;
    logic [wdt_pkg::ADDR_W-1:0] awaddr = '0;
    logic [wdt_pkg::ADDR_W-1:0] araddr = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b0;
    logic rready = 1'b0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic irq, interval_irq, reset_req;
    logic [15:0] ovf_tab [0:7] = '{`WDT_OVF_0, `WDT_OVF_1, `WDT_OVF_2,
        `WDT_OVF_3, `WDT_OVF_4, `WDT_OVF_5, `WDT_OVF_6, `WDT_OVF_7};
    int fails = 0;
    int total_checks = 0;
    int ticks = 0;
    int rst_seen = 0;
    int int_seen = 0;
    int rst_tick = 0;
    int int_tick = 0;

    wdt_core wdt_core_inst (
        .CLOCK_I(clock), .RST_I(rst), .LS_CLOCK_I(ls_clock),
        .OPTION_I(option), .STANDBY_I(standby),
        .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
        .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
        .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
        .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
        .RVALID_O(rvalid), .RREADY_I(rready), .IRQ_O(irq),
        .INTERVAL_IRQ_O(interval_irq), .RESET_REQ_O(reset_req)
    );

    // ------------------------------------------------------------------
    // Clock, pulse monitor and shared tasks
    // ------------------------------------------------------------------
    // 25 MHz system clock
    always #20 clock = ~clock;

    // Pulses are one cycle wide, so they are counted at every edge
    always @(posedge clock) begin
        if (reset_req === 1'b1) begin
            rst_seen <= rst_seen + 1;
            rst_tick <= ticks;
        end
        if (interval_irq === 1'b1) begin
            int_seen <= int_seen + 1;
            int_tick <= ticks;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Six cycles per slow period leaves room for the synchroniser
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock);
            ls_clock <= 1'b1;
            ticks++;
            repeat (3) @(posedge clock);
            ls_clock <= 1'b0;
            repeat (2) @(posedge clock);
        end
    endtask

    task automatic do_reset(input logic [4:0] opt);
        @(posedge clock);
        option <= opt;
        standby <= 1'b0;
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        rst_seen = 0;
        int_seen = 0;
        ticks = 0;
        rst_tick = 0;
        int_tick = 0;
    endtask

    // Address and data offered together, each released when taken
    task automatic axi_write(input logic [21:0] a, input logic [31:0] d,
                             input logic [3:0] s);
        int n;
        logic [1:0] er;
        n = 0;
        er = (a == BAD_A) ? `WDT_RESP_SLVERR : `WDT_RESP_OKAY;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            @(posedge clock);
            n++;
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                check({30'h0, bresp}, {30'h0, er});
                bready <= 1'b0;
                n = 100;
            end
        end
        if (n != 100) check(32'h0, 32'h1);
    endtask

    task automatic axi_read(input logic [21:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        n = 0;
        d = '1;
        r = '1;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(posedge clock);
            n++;
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                n = 100;
            end
        end
        if (n != 100) check(32'h0, 32'h2);
    endtask

    task automatic run_until(input int max);
        int k;
        for (k = 0; k < max && rst_seen == 0; k++) tick(1);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Read values, unmapped place, overflow, flags and interrupt line
    task automatic test_overflow_irq;
        logic [31:0] d;
        logic [1:0] r;
        do_reset(5'h10);
        axi_read(SVC_A, d, r);
        check(d, {24'h0, `WDT_READ_ENABLED});
        axi_read(MSK_A, d, r);
        check(d, {24'h0, `WDT_MASK_RESET});
        axi_read(BAD_A, d, r);
        check({30'h0, r}, {30'h0, `WDT_RESP_SLVERR});
        check(d, 32'h0);
        axi_write(BAD_A, 32'h0, 4'h1);
        axi_write(MSK_A, {24'h0, `WDT_ST_USED}, 4'h1);
        run_until(70);
        check(rst_tick, ovf_tab[0]);
        check(int_seen, 1);
        repeat (2) @(posedge clock);
        check(irq, 1'b1);
        axi_read(STS_A, d, r);
        check(d, {24'h0, `WDT_ST_USED});
        axi_write(STS_A, {24'h0, `WDT_ST_USED}, 4'h1);
        axi_read(STS_A, d, r);
        check(d, 32'h0);
        check(irq, 1'b0);
        axi_write(MSK_A, 32'h0, 4'h1);
        axi_write(SVC_A, 32'h55, 4'h1);
        repeat (3) @(posedge clock);
        check(irq, 1'b0);
        $display("test overflow and interrupt done");
    endtask

    // Select codes 0 to 5 each give their own overflow and interval count
    task automatic test_codes;
        int c;
        for (c = 0; c < 6; c++) begin
            do_reset({1'b1, c[2:0], 1'b0});
            run_until(ovf_tab[c] + 4);
            check(rst_tick, ovf_tab[c]);
            check(int_tick, 3 * (ovf_tab[c] + 1) / 4);
        end
        $display("test select codes done");
    endtask

    // Service in the last count, then a full period after it
    task automatic test_service;
        logic [31:0] d;
        logic [1:0] r;
        do_reset(5'h10);
        tick(62);
        // Key lands in the very cycle of the overflowing tick
        fork
            tick(1);
            begin
                @(posedge clock);
                axi_write(SVC_A, {24'h0, `WDT_SERVICE_KEY},
                          `WDT_BYTE_STRB);
            end
        join
        tick(2);
        check(rst_seen, 0);
        tick(60);
        check(rst_seen, 0);
        check(int_seen, 2);
        tick(1);
        check(rst_seen, 1);
        axi_read(SVC_A, d, r);
        check(d, {24'h0, `WDT_READ_ENABLED});
        $display("test service done");
    endtask

    // Wrong value and partial-lane write both trip the reset
    task automatic test_bad_writes;
        logic [31:0] d;
        logic [1:0] r;
        do_reset(5'h10);
        axi_write(SVC_A, 32'h55, `WDT_BYTE_STRB);
        repeat (3) @(posedge clock);
        check(rst_seen, 1);
        axi_write(SVC_A, {24'h0, `WDT_SERVICE_KEY}, 4'h3);
        repeat (3) @(posedge clock);
        check(rst_seen, 2);
        axi_read(STS_A, d, r);
        check(d & 32'h10, 32'h10);
        $display("test bad writes done");
    endtask

    // Disabled counter, then both standby options
    task automatic test_modes;
        logic [31:0] d;
        logic [1:0] r;
        do_reset(5'h00);
        axi_read(SVC_A, d, r);
        check(d, {24'h0, `WDT_READ_DISABLED});
        tick(80);
        check(rst_seen + int_seen, 0);
        do_reset(5'h10);
        tick(30);
        standby <= 1'b1;
        tick(70);
        check(rst_seen, 0);
        standby <= 1'b0;
        repeat (4) @(posedge clock);
        tick(62);
        check(rst_seen, 0);
        tick(1);
        check(rst_seen, 1);
        do_reset(5'h11);
        standby <= 1'b1;
        tick(63);
        check(rst_seen, 1);
        standby <= 1'b0;
        $display("test modes done");
    endtask

    // ------------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------------
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Longest code dominates the run; margin kept under the budget
    initial begin
        repeat (98000) @(posedge clock);
        fails++;
        complete_run();
    end

    initial begin
        test_overflow_irq();
        test_service();
        test_bad_writes();
        test_modes();
        test_codes();
        complete_run();
    end
endmodule
